/* include/rpg_defs.svh */
// Constants shared by both ends of the reset and input-gating link.
`ifndef RPG_DEFS_SVH
`define RPG_DEFS_SVH

`define RPG_CLK_NS          4
`define RPG_RECOV_NS        120
`define RPG_RECOV_CYC       (`RPG_RECOV_NS / `RPG_CLK_NS)
`define RPG_WARM_NS         150
`define RPG_WARM_CYC        ((`RPG_WARM_NS + `RPG_CLK_NS - 1) / `RPG_CLK_NS)
`define RPG_POR_NS          1000000
`define RPG_POR_CYC         ((`RPG_POR_NS + `RPG_CLK_NS - 1) / `RPG_CLK_NS)
`define RPG_ABORT_NS        25000
`define RPG_ABORT_CYC       ((`RPG_ABORT_NS + `RPG_CLK_NS - 1) / `RPG_CLK_NS)
`define RPG_CFG_LOAD_CYC    8
`define RPG_PROG_CYC        64

`define RPG_OFS_PMR_FIRST   8'h00
`define RPG_OFS_PMR_SECOND  8'h01
`define RPG_OFS_MEM_MAP     8'h02
`define RPG_OFS_IO_DIR      8'h03
`define RPG_OFS_STATUS      8'h04

`define RPG_PMR1_CLK_OFF    4
`define RPG_PMR2_ADDR_OFF   0
`define RPG_PMR2_CTL_LSB    2
`define RPG_PMR2_ALE_OFF    5
`define RPG_PMR2_HWBE_OFF   6
`define RPG_MM_SRAM_CODE    7
`define RPG_MM_RESET        8'h12

`define RPG_H_CTRL          32'h0000_0000
`define RPG_H_ACCESS        32'h0000_0004
`define RPG_H_STATUS        32'h0000_0008
`define RPG_H_PINS          32'h0000_000c

`endif

/* include/rpg_pkg.sv */
// Types shared by both ends of the reset and input-gating link.
package rpg_pkg;
  typedef enum logic [1:0] {RPG_TGT_REG, RPG_TGT_MAIN, RPG_TGT_SEC} rpg_target_type;
  typedef enum {RPG_FL_READ, RPG_FL_BUSY, RPG_FL_ABORT} rpg_flash_type;
  typedef enum {RPG_H_IDLE, RPG_H_RST, RPG_H_WAIT, RPG_H_STROBE, RPG_H_ACK} rpg_host_type;
endpackage : rpg_pkg

/* include/rpg_link_if.sv */
// Link between the host controller and the device: reset, strobes, data and array inputs.
`timescale 1ns/1ns
interface rpg_link_if;
  logic       reset_n;
  logic       main_flash_select_n;
  logic       secondary_flash_select_n;
  logic       reg_select_n;
  logic       write_strobe_n;
  logic [7:0] addr;
  logic [7:0] data_h_out;
  logic       data_h_oe;
  logic [7:0] data_d_out;
  logic       data_d_oe;
  logic [2:0] bus_control_inputs;
  logic       ale;
  logic       high_write_byte_enable;
  logic       common_clock_input;
  logic       dev_ready;

  modport device (input reset_n, main_flash_select_n, secondary_flash_select_n, reg_select_n,
                  write_strobe_n, addr, data_h_out, data_h_oe, bus_control_inputs, ale,
                  high_write_byte_enable, common_clock_input,
                  output data_d_out, data_d_oe, dev_ready);
  modport host   (output reset_n, main_flash_select_n, secondary_flash_select_n, reg_select_n,
                  write_strobe_n, addr, data_h_out, data_h_oe, bus_control_inputs, ale,
                  high_write_byte_enable, common_clock_input,
                  input data_d_out, data_d_oe, dev_ready);
endinterface : rpg_link_if

/* verilog/rpg_device.sv */
// Device end: reset sequencing, power mode registers, array input gating, flash abort.
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "rpg_defs.svh"

//------------------------------------------------------------------------------
// Device
//------------------------------------------------------------------------------
module rpg_device
  import rpg_pkg::*;
#(
  parameter int          ABORT_CYC = `RPG_ABORT_CYC,
  parameter int          PROG_CYC  = `RPG_PROG_CYC,
  parameter logic [7:0]  MM_CONFIG = `RPG_MM_RESET
)(
  input  wire logic       clk,
  input  wire logic       srst,
  rpg_link_if.device      link,
  input  wire logic       power_down,
  input  wire logic       write_lockout_voltage,
  output logic            pla_valid,
  output logic            pla_clock,
  output logic [7:0]      pla_addr,
  output logic [2:0]      pla_bus_control,
  output logic            pla_ale,
  output logic            pla_hwbe,
  output logic [7:0]      io_oe,
  output logic            addr_out_oe,
  output logic            flash_busy,
  output logic            flash_read_mode,
  output logic [7:0]      power_mode_reg_first,
  output logic [7:0]      power_mode_reg_second,
  output logic [7:0]      memory_map_register
);

  localparam int RECOV_CYC = `RPG_RECOV_CYC;

  logic          rst_meta_r;
  logic          rst_sync_r;
  logic          in_reset;
  logic          por_pending_r;
  logic [3:0]    cfg_cnt_r;
  logic          pla_valid_r;
  logic [5:0]    recov_cnt_r;
  logic          ready_r;
  logic [7:0]    io_dir_r;
  logic [7:0]    rdata_r;
  logic          rd_oe_r;
  logic          access;
  logic          wr;
  logic          start_flash;
  rpg_flash_type fl_state_r;
  logic [15:0]   fl_cnt_r;

  //------------------------------------------------------------------------------
  // Reset synchroniser and recovery
  //------------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= 1'b1;
    end
    else
    begin
      rst_meta_r <= ~link.reset_n;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign in_reset = rst_sync_r;

  // Counts the recovery interval after the synchronised release.
  always_ff @(posedge clk)
  begin
    if (srst || in_reset)
    begin
      recov_cnt_r <= '0;
      ready_r     <= 1'b0;
    end
    else if (!ready_r)
    begin
      if (recov_cnt_r == 6'(RECOV_CYC - 1))
        ready_r <= 1'b1;
      recov_cnt_r <= recov_cnt_r + 6'd1;
    end
  end

  assign link.dev_ready = ready_r;

  // The first reset after power-up is the power-on reset; it loads configuration.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      por_pending_r <= 1'b1;
      cfg_cnt_r     <= '0;
      pla_valid_r   <= 1'b0;
    end
    else if (in_reset && por_pending_r && !pla_valid_r)
    begin
      cfg_cnt_r <= cfg_cnt_r + 4'd1;
      if (cfg_cnt_r == 4'(`RPG_CFG_LOAD_CYC - 1))
        pla_valid_r <= 1'b1;
    end
    else if (!in_reset && pla_valid_r)
      por_pending_r <= 1'b0;
  end

  assign pla_valid = pla_valid_r;

  //------------------------------------------------------------------------------
  // Register access
  //------------------------------------------------------------------------------
  assign access = ready_r && !power_down
                  && !(link.reg_select_n && link.main_flash_select_n
                       && link.secondary_flash_select_n);
  assign wr     = access && !link.write_strobe_n && link.data_h_oe;

  always_ff @(posedge clk)
  begin
    if (srst || (in_reset && por_pending_r))
    begin
      power_mode_reg_first  <= 8'h00;
      power_mode_reg_second <= 8'h00;
    end
    else if (wr && !link.reg_select_n)
    begin
      if (link.addr == `RPG_OFS_PMR_FIRST)
        power_mode_reg_first <= link.data_h_out;
      if (link.addr == `RPG_OFS_PMR_SECOND)
        power_mode_reg_second <= link.data_h_out;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || in_reset)
    begin
      memory_map_register <= MM_CONFIG & ~(8'h01 << `RPG_MM_SRAM_CODE);
      io_dir_r            <= 8'h00;
    end
    else if (wr && !link.reg_select_n)
    begin
      if (link.addr == `RPG_OFS_MEM_MAP)
        memory_map_register <= link.data_h_out;
      if (link.addr == `RPG_OFS_IO_DIR)
        io_dir_r <= link.data_h_out;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || in_reset)
    begin
      rd_oe_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      rd_oe_r <= access && link.write_strobe_n && !link.reg_select_n;
      unique case (link.addr)
        `RPG_OFS_PMR_FIRST:  rdata_r <= power_mode_reg_first;
        `RPG_OFS_PMR_SECOND: rdata_r <= power_mode_reg_second;
        `RPG_OFS_MEM_MAP:    rdata_r <= memory_map_register;
        `RPG_OFS_IO_DIR:     rdata_r <= io_dir_r;
        `RPG_OFS_STATUS:     rdata_r <= {5'h00, write_lockout_voltage, flash_read_mode, flash_busy};
        default:             rdata_r <= 8'h00;
      endcase
    end
  end

  assign link.data_d_out = rdata_r;
  assign link.data_d_oe  = rd_oe_r;

  // In power-down the port directions hold; address out stays released.
  assign io_oe       = in_reset ? 8'h00 : io_dir_r;
  assign addr_out_oe = 1'b0;

  //------------------------------------------------------------------------------
  // Array input gating
  //------------------------------------------------------------------------------
  assign pla_clock       = link.common_clock_input
                           & ~power_mode_reg_first[`RPG_PMR1_CLK_OFF];
  assign pla_addr        = power_mode_reg_second[`RPG_PMR2_ADDR_OFF]
                           ? 8'h00 : link.addr;
  assign pla_bus_control = link.bus_control_inputs
                           & ~power_mode_reg_second[`RPG_PMR2_CTL_LSB +: 3];
  assign pla_ale         = link.ale & ~power_mode_reg_second[`RPG_PMR2_ALE_OFF];
  assign pla_hwbe        = link.high_write_byte_enable
                           & ~power_mode_reg_second[`RPG_PMR2_HWBE_OFF];

  //------------------------------------------------------------------------------
  // Flash state machine
  //------------------------------------------------------------------------------
  assign start_flash = wr && (!link.main_flash_select_n || !link.secondary_flash_select_n)
                       && !write_lockout_voltage;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fl_state_r <= RPG_FL_READ;
      fl_cnt_r   <= '0;
    end
    else
    begin
      unique case (fl_state_r)
        RPG_FL_READ:
          if (start_flash && !in_reset)
          begin
            fl_state_r <= RPG_FL_BUSY;
            fl_cnt_r   <= '0;
          end
        RPG_FL_BUSY:
          if (in_reset)
          begin
            fl_state_r <= RPG_FL_ABORT;
            fl_cnt_r   <= '0;
          end
          else if (fl_cnt_r == 16'(PROG_CYC - 1))
            fl_state_r <= RPG_FL_READ;
          else
            fl_cnt_r <= fl_cnt_r + 16'd1;
        RPG_FL_ABORT:
          if (fl_cnt_r == 16'(ABORT_CYC - 1))
            fl_state_r <= RPG_FL_READ;
          else
            fl_cnt_r <= fl_cnt_r + 16'd1;
      endcase
    end
  end

  assign flash_busy      = fl_state_r != RPG_FL_READ;
  assign flash_read_mode = fl_state_r == RPG_FL_READ;

endmodule : rpg_device

/* verilog/rpg_host.sv */
// Host end: AHB-Lite register slave driving reset pulses and strobed link accesses.
`timescale 1ns/1ns
`include "rpg_defs.svh"

module rpg_host
  import rpg_pkg::*;
#(
  parameter int POR_CYC  = `RPG_POR_CYC,
  parameter int WARM_CYC = `RPG_WARM_CYC
)(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  rpg_link_if.host         link
);

  rpg_host_type   st_r;
  logic           wr_pend_r;
  logic [31:0]    addr_r;
  logic [19:0]    cnt_r;
  logic [19:0]    pulse_r;
  logic [18:0]    acc_r;
  logic [13:0]    pins_r;
  logic [7:0]     rdata_r;
  logic           done_r;
  logic           wr_en;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  //------------------------------------------------------------------------------
  // AHB-Lite slave
  //------------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_pend_r <= 1'b0;
      addr_r    <= '0;
      hrdata    <= '0;
    end
    else if (hready)
    begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      addr_r    <= haddr;
      unique case (haddr)
        `RPG_H_ACCESS: hrdata <= {13'h0000, acc_r};
        `RPG_H_STATUS: hrdata <= {16'h0000, rdata_r, 4'h0, done_r,
                                  st_r == RPG_H_IDLE ? 1'b0 : 1'b1, 1'b0, link.dev_ready};
        `RPG_H_PINS:   hrdata <= {18'h00000, pins_r};
        default:       hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign wr_en = wr_pend_r && st_r == RPG_H_IDLE;

  always_ff @(posedge clk)
  begin
    if (srst)
      pins_r <= '0;
    else if (wr_pend_r && addr_r == `RPG_H_PINS)
      pins_r <= hwdata[13:0];
  end

  //------------------------------------------------------------------------------
  // Reset pulses and link access sequencer
  //------------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r    <= RPG_H_IDLE;
      cnt_r   <= '0;
      pulse_r <= '0;
      acc_r   <= '0;
      rdata_r <= '0;
      done_r  <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        RPG_H_IDLE:
          if (wr_en && addr_r == `RPG_H_CTRL && (hwdata[0] || hwdata[1]))
          begin
            pulse_r <= hwdata[0] ? 20'(POR_CYC) : 20'(WARM_CYC);
            cnt_r   <= '0;
            st_r    <= RPG_H_RST;
          end
          else if (wr_en && addr_r == `RPG_H_ACCESS)
          begin
            acc_r  <= hwdata[18:0];
            done_r <= 1'b0;
            st_r   <= RPG_H_WAIT;
          end
        RPG_H_RST:
          if (cnt_r == pulse_r - 20'd1)
            st_r <= RPG_H_IDLE;
          else
            cnt_r <= cnt_r + 20'd1;
        RPG_H_WAIT:
          if (link.dev_ready)
            st_r <= RPG_H_STROBE;
        RPG_H_STROBE:
          st_r <= acc_r[18] ? RPG_H_IDLE : RPG_H_ACK;
        RPG_H_ACK:
          if (link.data_d_oe)
          begin
            rdata_r <= link.data_d_out;
            st_r    <= RPG_H_IDLE;
          end
      endcase
      if (st_r == RPG_H_STROBE && acc_r[18])
        done_r <= 1'b1;
      if (st_r == RPG_H_ACK && link.data_d_oe)
        done_r <= 1'b1;
    end
  end

  // Selects and write strobe stay inactive outside the strobe cycle, so never in reset.
  assign link.reset_n                  = st_r != RPG_H_RST;
  assign link.reg_select_n             = !(st_r == RPG_H_STROBE
                                           && acc_r[17:16] == RPG_TGT_REG);
  assign link.main_flash_select_n      = !(st_r == RPG_H_STROBE
                                           && acc_r[17:16] == RPG_TGT_MAIN);
  assign link.secondary_flash_select_n = !(st_r == RPG_H_STROBE
                                           && acc_r[17:16] == RPG_TGT_SEC);
  assign link.write_strobe_n           = !(st_r == RPG_H_STROBE && acc_r[18]);
  assign link.data_h_oe                = st_r == RPG_H_STROBE && acc_r[18];
  assign link.addr                     = st_r == RPG_H_STROBE ? acc_r[15:8] : pins_r[7:0];
  assign link.data_h_out               = acc_r[7:0];
  assign link.bus_control_inputs       = pins_r[10:8];
  assign link.ale                      = pins_r[11];
  assign link.high_write_byte_enable   = pins_r[12];
  assign link.common_clock_input       = pins_r[13];

endmodule : rpg_host

/* sim/rpg_link_props.sv */
// Concurrent checks on the link between the host end and the device end.
`timescale 1ns/1ns

module rpg_link_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_n,
  input wire logic main_flash_select_n,
  input wire logic secondary_flash_select_n,
  input wire logic reg_select_n,
  input wire logic write_strobe_n,
  input wire logic data_d_oe,
  input wire logic dev_ready
);
  logic [7:0] hi_cnt_r;
  logic       strobe;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  //----------------------------------------------------------------------------
  // Cycles since reset was last released
  //----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst || !reset_n)
      hi_cnt_r <= 8'h00;
    else if (hi_cnt_r != 8'hff)
      hi_cnt_r <= hi_cnt_r + 8'h01;
  end

  assign strobe = !reg_select_n || !main_flash_select_n || !secondary_flash_select_n;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  a_ready_recovery: assert property ($rose(dev_ready) |-> hi_cnt_r inside {[8'h1e:8'h23]})
    else $error("ready rose outside the recovery window");
  a_no_early_access: assert property (strobe |-> hi_cnt_r >= 8'h1e)
    else $error("access strobe before recovery ended");
  a_quiet_in_reset: assert property (!reset_n |-> main_flash_select_n && secondary_flash_select_n
                                     && reg_select_n && write_strobe_n)
    else $error("select or strobe active during reset");
  a_ready_drop: assert property ($fell(reset_n) |-> ##[1:4] !dev_ready)
    else $error("ready did not drop after reset");
  a_ready_held: assert property (!reset_n [*4] |-> !dev_ready)
    else $error("ready high while reset held");
  a_data_tristate: assert property (!reset_n [*3] |-> !data_d_oe)
    else $error("data port driven during reset");
  a_read_answer: assert property (data_d_oe |-> $past(strobe) && $past(write_strobe_n))
    else $error("data port driven without a read strobe");
  a_answer_once: assert property (data_d_oe |=> !data_d_oe)
    else $error("data port driven longer than one cycle");
  a_strobe_single: assert property (!write_strobe_n |=> write_strobe_n)
    else $error("write strobe longer than one cycle");
endmodule : rpg_link_props

/* sim/reset_and_pld_input_gating_tb_top.sv */
// Self-checking bench driving the host end over AHB-Lite with the device end on its link.
`timescale 1ns/1ns
`include "rpg_defs.svh"

module reset_and_pld_input_gating_tb_top;
  localparam int ABORT = 20;
  localparam int POR   = 50;
  // Configured memory map value with the sram-as-code bit set, so that a reset must clear it.
  localparam logic [7:0] MM_CFG = 8'h92;

  logic        clk, srst, hsel, hwrite, hready, hreadyout, hresp;
  logic        power_down, write_lockout_voltage;
  logic [31:0] haddr, hwdata, hrdata, st;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pla_ctl;
  logic        pla_valid, pla_clock, pla_ale, pla_hwbe, addr_out_oe, flash_busy, flash_read_mode;
  logic [7:0]  pla_addr, io_oe, pmr1, pmr2, mm, rd;
  logic [12:0] exp_g;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          lo_cnt = 0;
  int          last_lo = 0;
  int          n;

  assign hready = hreadyout;
  rpg_link_if link();
  rpg_host #(.POR_CYC(POR)) rpg_host_i (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
  rpg_device #(.ABORT_CYC(ABORT), .MM_CONFIG(MM_CFG)) rpg_device_i (.clk(clk), .srst(srst),
    .link(link),
    .power_down(power_down), .write_lockout_voltage(write_lockout_voltage),
    .pla_valid(pla_valid), .pla_clock(pla_clock), .pla_addr(pla_addr),
    .pla_bus_control(pla_ctl), .pla_ale(pla_ale), .pla_hwbe(pla_hwbe), .io_oe(io_oe),
    .addr_out_oe(addr_out_oe), .flash_busy(flash_busy), .flash_read_mode(flash_read_mode),
    .power_mode_reg_first(pmr1), .power_mode_reg_second(pmr2), .memory_map_register(mm));
  rpg_link_props rpg_link_props_i (.clk(clk), .srst(srst), .reset_n(link.reset_n),
    .main_flash_select_n(link.main_flash_select_n), .reg_select_n(link.reg_select_n),
    .secondary_flash_select_n(link.secondary_flash_select_n),
    .write_strobe_n(link.write_strobe_n), .data_d_oe(link.data_d_oe),
    .dev_ready(link.dev_ready));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Length of the last reset pulse seen on the link.
  always @(posedge clk)
  begin
    if (link.reset_n === 1'b0)
      lo_cnt <= lo_cnt + 1;
    else if (lo_cnt != 0)
    begin
      last_lo <= lo_cnt;
      lo_cnt  <= 0;
    end
  end

  //----------------------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------------------
  task stop_test;
    $display("errors %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task ahb(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  task dev_acc(input logic w, input logic [1:0] tg, input logic [7:0] a, input logic [7:0] d);
    ahb(`RPG_H_ACCESS, 1'b1, {13'h0, w, tg, a, d}, st);
    repeat (2) @(posedge clk);
    st = 32'h4;
    for (int i = 0; i < 300 && st[2] !== 1'b0; i++)
      ahb(`RPG_H_STATUS, 1'b0, 32'h0, st);
    chk("access done", 32'h2, {30'h0, st[3:2]});
    rd = st[15:8];
  endtask : dev_acc

  task wait_ready;
    st = 32'h0;
    for (int i = 0; i < 300 && st[0] !== 1'b1; i++)
      ahb(`RPG_H_STATUS, 1'b0, 32'h0, st);
    chk("dev ready", 32'h1, {31'h0, st[0]});
  endtask : wait_ready

  task rst_pulse(input logic [31:0] kind);
    ahb(`RPG_H_CTRL, 1'b1, kind, st);
    for (int i = 0; i < 50 && link.reset_n !== 1'b0; i++)
      @(posedge clk);
    chk("reset low", 32'h0, {31'h0, link.reset_n});
  endtask : rst_pulse

  task negs(input int k);
    repeat (k) @(negedge clk);
  endtask : negs

  //----------------------------------------------------------------------------
  // Tests
  //----------------------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    {hsel, hwrite, power_down, write_lockout_voltage} = 4'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    negs(1);
    chk("pmr1", 32'h0, {24'h0, pmr1});
    chk("pmr2", 32'h0, {24'h0, pmr2});
    chk("read mode", 32'h1, {31'h0, flash_read_mode});
    chk("addr out oe", 32'h0, {31'h0, addr_out_oe});
    wait_ready;
    chk("ready", 32'h1, {31'h0, st[0]});
    dev_acc(1'b1, 2'd0, `RPG_OFS_PMR_FIRST, 8'h10);
    chk("pmr1 set", 32'h10, {24'h0, pmr1});
    rst_pulse(32'h1);
    negs(12);
    chk("pla valid", 32'h1, {31'h0, pla_valid});
    wait_ready;
    chk("por length", 32'h1, {31'h0, last_lo >= POR});
    chk("pmr1 por", 32'h0, {24'h0, pmr1});
    ahb(`RPG_H_PINS, 1'b1, 32'h3fff, st);
    negs(2);
    chk("array clock on", 32'h1, {31'h0, pla_clock});
    chk("inputs open", 32'h1fff, {19'h0, pla_hwbe, pla_ale, pla_ctl, pla_addr});
    dev_acc(1'b1, 2'd0, `RPG_OFS_PMR_FIRST, 8'h10);
    negs(1);
    chk("array clock off", 32'h0, {31'h0, pla_clock});
    for (int b = 0; b < 7; b++)
    begin
      if (b != 1)
      begin
        dev_acc(1'b1, 2'd0, `RPG_OFS_PMR_SECOND, 8'h01 << b);
        negs(1);
        exp_g = (b == 0) ? 13'h1f00 : 13'h1fff & ~(13'h0001 << (b + 6));
        chk("gated inputs", {19'h0, exp_g}, {19'h0, pla_hwbe, pla_ale, pla_ctl, pla_addr});
      end
    end
    dev_acc(1'b1, 2'd0, `RPG_OFS_PMR_SECOND, 8'h7d);
    dev_acc(1'b0, 2'd0, `RPG_OFS_PMR_SECOND, 8'h00);
    chk("pmr2 readback", 32'h7d, {24'h0, rd});
    dev_acc(1'b1, 2'd0, `RPG_OFS_MEM_MAP, 8'h9f);
    dev_acc(1'b1, 2'd0, `RPG_OFS_IO_DIR, 8'hff);
    negs(1);
    chk("io out", 32'hff, {24'h0, io_oe});
    @(posedge clk);
    power_down <= 1'b1;
    dev_acc(1'b1, 2'd0, `RPG_OFS_IO_DIR, 8'h00);
    negs(1);
    chk("io held", 32'hff, {24'h0, io_oe});
    @(posedge clk);
    power_down <= 1'b0;
    write_lockout_voltage <= 1'b1;
    dev_acc(1'b1, 2'd1, 8'h00, 8'h5a);
    negs(1);
    chk("lockout", 32'h0, {31'h0, flash_busy});
    @(posedge clk);
    write_lockout_voltage <= 1'b0;
    dev_acc(1'b1, 2'd2, 8'h00, 8'ha5);
    negs(1);
    chk("program", 32'h0, {31'h0, flash_read_mode});
    dev_acc(1'b0, 2'd0, `RPG_OFS_STATUS, 8'h00);
    chk("flash status", 32'h1, {24'h0, rd});
    rst_pulse(32'h2);
    negs(6);
    chk("io in reset", 32'h0, {24'h0, io_oe});
    chk("pla valid warm", 32'h1, {31'h0, pla_valid});
    n = 6;
    while (flash_read_mode !== 1'b1 && n < 200)
    begin
      negs(1);
      n++;
    end
    chk("abort time", 32'h1, {31'h0, n <= ABORT + 6});
    wait_ready;
    chk("warm length", 32'h1, {31'h0, last_lo >= `RPG_WARM_CYC});
    chk("pmr1 warm", 32'h10, {24'h0, pmr1});
    chk("pmr2 warm", 32'h7d, {24'h0, pmr2});
    chk("mem map warm", 32'h12, {24'h0, mm});
    stop_test;
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
endmodule : reset_and_pld_input_gating_tb_top
